/* File: rts_core_model.sv */
// rts_core_model.sv: processor core as seen from the sequencer
// assumes core_start is high only while the core may fetch
`timescale 1ns/1ns
module rts_core_model (
	// handoff
	input wire core_start,
	// bench command and fetch fault
	input wire bad_fetch,
	output wire periph_fetch
);
	// a core held in reset fetches nothing, so a stray fault needs a run
	assign periph_fetch = bad_fetch && core_start;
endmodule // rts_core_model

/* File: rts_map.vh */
// rts_map.vh: register offsets, field positions, reset values and
// timing counts of the reset trigger sequencer.
// assumes a 100 MHz mclk and a 32-bit Avalon-MM slave port.
`ifndef RTS_MAP_VH
`define RTS_MAP_VH

// register byte offsets
`define RTS_REG_CAUSE 4'h0
`define RTS_REG_IRQ_STAT 4'h4
`define RTS_REG_IRQ_MASK 4'h8
`define RTS_REG_CTRL 4'hc

// cause flags, sticky until written one
`define RTS_C_PWRUP 0
`define RTS_C_PIN 1
`define RTS_C_WAKE 2
`define RTS_C_SWBOR 3
`define RTS_C_SVS 4
`define RTS_C_SWPOR 5
`define RTS_C_WDT 6
`define RTS_C_PWV 7
`define RTS_C_FETCH 8
`define RTS_C_SWPUC 9
`define RTS_CAUSE_W 10

// interrupt status / mask bits
`define RTS_I_SVS_LOW 0
`define RTS_I_SVM_LOW 1
`define RTS_I_SVM_OVER 2
`define RTS_I_BOOT_DONE 3
`define RTS_IRQ_W 4

// control register fields
`define RTS_K_SVS_RST 0
`define RTS_K_SVM_RST 1
`define RTS_K_SVM_OV_EN 2
`define RTS_K_SWBOR 8
`define RTS_K_SWPOR 9
`define RTS_K_SWPUC 10
`define RTS_CTRL_RST 3'h1

// fixed release stretch per level and calibration length, in ns, then in cycles
`define RTS_CLK_NS 10
`define RTS_HOLD_NS 160
`define RTS_HOLD_CYC 8'h10
`define RTS_CALIB_NS 320
`define RTS_CALIB_CYC 8'h20

`define RTS_RESET_VECTOR 16'hffff

`endif

/* File: rts_reset_sequencer.v */
// rts_reset_sequencer.v: three nested reset levels, cause flags, boot
// calibration step, core start handoff and supply event interrupts.
// assumes async reset sources arrive unsynchronised from pins/analog and
// the core and software sit on mclk behind an Avalon-MM slave.
`timescale 1ns/1ns
`include "rts_map.vh"

module rts_reset_sequencer #(
	parameter HAS_BOR = 1,
	parameter SVS_FIXED = 0
) (
	// clock and bus reset
	input wire mclk,
	input wire reset,
	// external and analog sources, asynchronous
	input wire supply_good,
	input wire rst_nmi_pin_n,
	input wire wake_deepest_sleep,
	input wire svs_low,
	input wire svm_low,
	input wire svm_over,
	// internal fault pulses, mclk domain
	input wire wdt_event,
	input wire pw_violation,
	input wire periph_fetch,
	// interrupt requests toward the core
	input wire nmi_req,
	input wire nmi_en,
	input wire [7:0] mask_req,
	input wire [7:0] mask_en,
	input wire global_irq_enable,
	// avalon-mm slave
	input wire [3:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	output reg [31:0] avs_readdata,
	output reg avs_waitrequest,
	// reset levels, core handoff and interrupt outputs
	output reg brownout_reset_level,
	output reg power_on_level,
	output reg power_up_clear_level,
	output reg calib_load,
	output reg core_start,
	output reg [15:0] core_vector_addr,
	output reg [1:0] irq_class,
	output reg irq_out
);

	localparam S_RESET = 3'b001;
	localparam S_CALIB = 3'b010;
	localparam S_RUN = 3'b100;

	// async inputs: two flops each, first flop read only by second
	reg [5:0] sy1_q, sy2_q;
	wire [5:0] raw_in = {svm_over, svm_low, svs_low, wake_deepest_sleep,
		~rst_nmi_pin_n, ~supply_good};
	always @(posedge mclk) begin
		sy1_q <= raw_in;
		sy2_q <= sy1_q;
	end
	wire pwr_bad = sy2_q[0];
	wire pin_act = sy2_q[1];
	wire wake_ev = sy2_q[2];
	wire svs_dn = sy2_q[3];
	wire svm_dn = sy2_q[4];
	wire svm_ov = sy2_q[5];

	reg [2:0] ctrl_q;
	reg sw_bor_q, sw_por_q, sw_puc_q;
	reg [`RTS_CAUSE_W-1:0] cause_q;
	reg [`RTS_IRQ_W-1:0] ist_q, imask_q;
	reg [2:0] st_q;
	reg [7:0] bor_cnt_q, por_cnt_q, puc_cnt_q, cal_cnt_q;
	// supervisor routes to reset or interrupt per control bit; SVS_FIXED forces svs to reset
	wire svs_rst = svs_dn & (SVS_FIXED != 0 | ctrl_q[`RTS_K_SVS_RST]);
	wire svm_rst = svm_dn & ctrl_q[`RTS_K_SVM_RST];

	// level triggers; detector and pin go to power-on without bor
	wire bor_trig = (HAS_BOR != 0) & (pwr_bad | pin_act | wake_ev |
		sw_bor_q | svs_rst);
	wire por_trig = sw_por_q | svm_rst |
		((HAS_BOR == 0) & (pwr_bad | pin_act | svs_rst));
	wire puc_trig = wdt_event | pw_violation | periph_fetch |
		sw_puc_q;

	// each level held while triggered, then released after a stretch;
	// higher level forces lower
	wire bor_on = bor_trig | (bor_cnt_q != 8'h00);
	wire por_on = bor_on | por_trig | (por_cnt_q != 8'h00);
	wire puc_on = por_on | puc_trig | (puc_cnt_q != 8'h00);

	always @(posedge mclk) begin
		if (reset) begin
			bor_cnt_q <= `RTS_HOLD_CYC;
			por_cnt_q <= `RTS_HOLD_CYC;
			puc_cnt_q <= `RTS_HOLD_CYC;
			brownout_reset_level <= 1'b1;
			power_on_level <= 1'b1;
			power_up_clear_level <= 1'b1;
		end else begin
			bor_cnt_q <= bor_trig ? `RTS_HOLD_CYC :
				(bor_cnt_q != 8'h00 ? bor_cnt_q - 8'h01 : 8'h00);
			por_cnt_q <= (bor_on | por_trig) ? `RTS_HOLD_CYC :
				(por_cnt_q != 8'h00 ? por_cnt_q - 8'h01 : 8'h00);
			puc_cnt_q <= (por_on | puc_trig) ? `RTS_HOLD_CYC :
				(puc_cnt_q != 8'h00 ? puc_cnt_q - 8'h01 : 8'h00);
			brownout_reset_level <= bor_on;
			power_on_level <= por_on;
			power_up_clear_level <= puc_on;
		end
	end

	// boot sequence: calibration only after a brownout
	reg bor_seen_q;
	always @(posedge mclk) begin
		if (reset) begin
			st_q <= S_RESET;
			bor_seen_q <= 1'b1;
			cal_cnt_q <= 8'h00;
			calib_load <= 1'b0;
			core_start <= 1'b0;
			core_vector_addr <= 16'h0000;
		end else begin
			if (puc_on) begin
				st_q <= S_RESET;
				calib_load <= 1'b0;
				core_start <= 1'b0;
				if (bor_on)
					bor_seen_q <= 1'b1;
			end else begin
				case (st_q)
				S_RESET: begin
					if (bor_seen_q) begin
						st_q <= S_CALIB;
						calib_load <= 1'b1;
						cal_cnt_q <= `RTS_CALIB_CYC;
					end else begin
						st_q <= S_RUN;
						core_start <= 1'b1;
						core_vector_addr <= `RTS_RESET_VECTOR;
					end
				end
				S_CALIB: begin
					if (cal_cnt_q == 8'h01) begin
						calib_load <= 1'b0;
						bor_seen_q <= 1'b0;
						st_q <= S_RUN;
						core_start <= 1'b1;
						core_vector_addr <= `RTS_RESET_VECTOR;
					end
					cal_cnt_q <= cal_cnt_q - 8'h01;
				end
				S_RUN: st_q <= S_RUN;
				default: st_q <= S_RESET;
				endcase
			end
		end
	end

	// bus access: one wait cycle, then answer
	wire wr = avs_write & ~avs_waitrequest;
	wire wr_cause = wr & avs_address == `RTS_REG_CAUSE;
	wire wr_ist = wr & avs_address == `RTS_REG_IRQ_STAT;

	// cause events: set wins over write-one clear
	wire [`RTS_CAUSE_W-1:0] cause_ev = {sw_puc_q, periph_fetch,
		pw_violation, wdt_event, sw_por_q | svm_rst, svs_rst, sw_bor_q,
		wake_ev, pin_act, pwr_bad};
	// supply and boot-done events into interrupt status
	reg svs_d1_q, svm_d1_q, ov_d1_q, st_run_q;
	wire [`RTS_IRQ_W-1:0] irq_ev = {
		(st_q == S_RUN) & ~st_run_q,
		ctrl_q[`RTS_K_SVM_OV_EN] & svm_ov & ~ov_d1_q,
		svm_dn & ~svm_d1_q & ~ctrl_q[`RTS_K_SVM_RST],
		svs_dn & ~svs_d1_q & ~svs_rst};

	always @(posedge mclk) begin
		if (reset) begin
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h0000_0000;
			ctrl_q <= `RTS_CTRL_RST;
			sw_bor_q <= 1'b0;
			sw_por_q <= 1'b0;
			sw_puc_q <= 1'b0;
			cause_q <= {`RTS_CAUSE_W{1'b0}};
			ist_q <= {`RTS_IRQ_W{1'b0}};
			imask_q <= {`RTS_IRQ_W{1'b0}};
			svs_d1_q <= 1'b0;
			svm_d1_q <= 1'b0;
			ov_d1_q <= 1'b0;
			st_run_q <= 1'b0;
		end else begin
			svs_d1_q <= svs_dn;
			svm_d1_q <= svm_dn;
			ov_d1_q <= svm_ov;
			st_run_q <= (st_q == S_RUN);
			avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
			sw_bor_q <= 1'b0;
			sw_por_q <= 1'b0;
			sw_puc_q <= 1'b0;
			cause_q <= (cause_q & ~(wr_cause ?
				avs_writedata[`RTS_CAUSE_W-1:0] : {`RTS_CAUSE_W{1'b0}}))
				| cause_ev;
			ist_q <= (ist_q & ~(wr_ist ?
				avs_writedata[`RTS_IRQ_W-1:0] : {`RTS_IRQ_W{1'b0}}))
				| irq_ev;
			if (wr & avs_address == `RTS_REG_IRQ_MASK)
				imask_q <= avs_writedata[`RTS_IRQ_W-1:0];
			if (wr & avs_address == `RTS_REG_CTRL) begin
				ctrl_q <= avs_writedata[2:0];
				sw_bor_q <= avs_writedata[`RTS_K_SWBOR];
				sw_por_q <= avs_writedata[`RTS_K_SWPOR];
				sw_puc_q <= avs_writedata[`RTS_K_SWPUC];
			end
			// loaded in the wait cycle so data stand at the answering edge
			if (avs_read & avs_waitrequest) begin
				case (avs_address)
				`RTS_REG_CAUSE:
					avs_readdata <= {22'h00_0000, cause_q};
				`RTS_REG_IRQ_STAT:
					avs_readdata <= {28'h000_0000, ist_q};
				`RTS_REG_IRQ_MASK:
					avs_readdata <= {28'h000_0000, imask_q};
				`RTS_REG_CTRL:
					avs_readdata <= {26'h000_0000, st_q, ctrl_q};
				default: avs_readdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// core request classes; fixed priority
	wire any_mask = |(mask_req & mask_en) & global_irq_enable;
	always @(posedge mclk) begin
		if (reset) begin
			irq_class <= 2'h0;
			irq_out <= 1'b0;
		end else begin
			if (puc_on)
				irq_class <= 2'h3; // reset class wins
			else if (nmi_req & nmi_en)
				irq_class <= 2'h2;
			else if (any_mask)
				irq_class <= 2'h1;
			else
				irq_class <= 2'h0;
			irq_out <= |(ist_q & imask_q);
		end
	end

endmodule // rts_reset_sequencer

/* File: rts_sva.sv */
// rts_sva.sv: port assertions for the reset trigger sequencer
// assumes one mclk domain with a synchronous active-high reset
`timescale 1ns/1ns
module rts_sva (
	// clock and reset
	input wire mclk,
	input wire reset,
	// sources
	input wire supply_good,
	input wire wdt_event,
	input wire pw_violation,
	// levels, handoff and interrupt
	input wire brownout_reset_level,
	input wire power_on_level,
	input wire power_up_clear_level,
	input wire calib_load,
	input wire core_start,
	input wire [15:0] core_vector_addr,
	input wire irq_out
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);
	chk_bor_por: assert property (brownout_reset_level |-> power_on_level)
		else $error("brownout without power-on");
	chk_por_puc: assert property (power_on_level |-> power_up_clear_level)
		else $error("power-on without clear");
	chk_supply_hold: assert property (!supply_good |-> ##[0:3] brownout_reset_level)
		else $error("low supply left device running");
	chk_wdt_clear: assert property (wdt_event |-> ##[0:3] power_up_clear_level)
		else $error("watchdog gave no clear");
	chk_pw_clear: assert property (pw_violation |-> ##[0:3] power_up_clear_level)
		else $error("password fault gave no clear");
	chk_start_vec: assert property (core_start |->
		core_vector_addr == 16'hffff && !power_up_clear_level)
		else $error("core ran in reset or off vector");
	chk_calib_first: assert property (calib_load |-> !core_start)
		else $error("core ran during calibration");
	chk_por_stretch: assert property ($fell(brownout_reset_level) |=>
		power_on_level[*8])
		else $error("power-on dropped with brownout");
	cover property ($rose(calib_load));
	cover property ($fell(power_up_clear_level));
	cover property ($rose(irq_out));
endmodule // rts_sva

bind rts_reset_sequencer rts_sva chk_u (.mclk, .reset, .supply_good,
	.wdt_event, .pw_violation, .brownout_reset_level, .power_on_level,
	.power_up_clear_level, .calib_load, .core_start, .core_vector_addr,
	.irq_out);

/* File: tb_top.sv */
// tb_top.sv: self-checking bench for the reset trigger sequencer
// assumes read data stand at the edge that sees waitrequest low
`timescale 1ns/1ns
module tb_top;
	logic mclk = 0, reset = 1, svm_low = 0, svm_over = 0, nmi_req = 0;
	logic nmi_en = 0, global_irq_enable = 0, avs_read = 0, avs_write = 0;
	logic probe = 0;
	logic [9:0] src = 0;
	logic [7:0] mask_req = 0, mask_en = 0;
	logic [3:0] avs_address = 0;
	logic [31:0] avs_writedata = 0, avs_readdata, got, r;
	logic [31:0] eq[$], mq[$];
	wire supply_good, rst_nmi_pin_n, wake_deepest_sleep, svs_low, wdt_event;
	wire pw_violation, periph_fetch, bad_fetch;
	logic avs_waitrequest, brownout_reset_level, power_on_level, irq_out;
	logic power_up_clear_level, calib_load, core_start;
	logic [15:0] core_vector_addr;
	logic [1:0] irq_class;
	int error_cnt = 0, samples_checked = 0;
	int cb[10] = '{6, 7, 8, 1, 2, 0, 3, 5, 9, 4};
	logic [2:0] lv[10] = '{1, 1, 1, 7, 7, 7, 7, 3, 1, 3};
	// pin and supply are active low, so idle src keeps them released
	assign {svs_low, supply_good, wake_deepest_sleep, rst_nmi_pin_n,
		bad_fetch, pw_violation, wdt_event} =
		{src[9], ~src[5], src[4], ~src[3], src[2:0]};
	rts_reset_sequencer dut_u (.mclk, .reset, .supply_good, .rst_nmi_pin_n,
		.wake_deepest_sleep, .svs_low, .svm_low, .svm_over, .wdt_event,
		.pw_violation, .periph_fetch, .nmi_req, .nmi_en, .mask_req, .mask_en,
		.global_irq_enable, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_readdata, .avs_waitrequest, .brownout_reset_level,
		.power_on_level, .power_up_clear_level, .calib_load, .core_start,
		.core_vector_addr, .irq_class, .irq_out);
	rts_core_model core_u (.core_start, .bad_fetch, .periph_fetch);
	initial begin
		forever #5 mclk = ~mclk;
	end
	// read data are taken at the edge where waitrequest is seen low
	always @(posedge mclk) begin
		if ((avs_read && !avs_waitrequest) || probe) begin
			got = avs_read ? avs_readdata : {26'h0, irq_class, irq_out,
				brownout_reset_level, power_on_level, power_up_clear_level};
			samples_checked++;
			if ((got & mq[0]) !== eq[0]) begin
				error_cnt++;
				$display("wrong value at %0t: got %h want %h", $time, got, eq[0]);
			end
			void'(eq.pop_front());
			void'(mq.pop_front());
		end
	end
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= !w;
		avs_write <= w;
		@(posedge mclk);
		while (avs_waitrequest !== 1'b0)
			@(posedge mclk);
		avs_read <= 0;
		avs_write <= 0;
		@(posedge mclk);
	endtask
	task automatic note(input logic [31:0] e, m);
		eq.push_back(e);
		mq.push_back(m);
	endtask
	task automatic rd_chk(input logic [3:0] a, input logic [31:0] e, m);
		note(e, m);
		bus(0, a, 0);
	endtask
	task automatic chk_lv(input logic [31:0] e, m);
		note(e, m);
		probe <= 1;
		@(posedge mclk);
		probe <= 0;
	endtask
	task automatic wait_run;
		while (core_start !== 1'b1)
			@(posedge mclk);
	endtask
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		void'($urandom(12305));
		repeat (20) @(posedge mclk);
		reset <= 0;
		for (int i = 0; i < 10; i++) begin
			wait_run();
			bus(1, 4'h0, 32'h3ff);
			if (i > 5 && i < 9)
				bus(1, 4'hc, 32'h1 | (32'h100 << (i - 6)));
			else
				src <= 10'h1 << i;
			repeat (3) @(posedge mclk);
			src <= 0;
			chk_lv(lv[i], i == 9 ? 3 : 7);
			wait_run();
			rd_chk(4'h0, 32'h1 << cb[i], 32'h1 << cb[i]);
			$display("trigger %0d done", i);
		end
		// supervisor routed to interrupt, over-voltage flag enabled
		bus(1, 4'hc, 32'h4);
		bus(1, 4'h8, 32'h0);
		bus(1, 4'h4, 32'hf);
		svm_low <= 1;
		svm_over <= 1;
		src <= 10'h200;
		repeat (4) @(posedge mclk);
		svm_low <= 0;
		svm_over <= 0;
		src <= 0;
		repeat (3) @(posedge mclk);
		chk_lv(0, 32'h8);
		rd_chk(4'h4, 32'h7, 32'h7);
		bus(1, 4'h8, 32'h2);
		repeat (3) @(posedge mclk);
		chk_lv(32'h8, 32'h8);
		bus(1, 4'h4, 32'h6);
		repeat (3) @(posedge mclk);
		chk_lv(0, 32'h8);
		$display("interrupt test done");
		bus(1, 4'h0, 32'h3ff);
		mask_req <= 8'h1 << ($urandom % 8);
		mask_en <= 8'hff;
		nmi_req <= 1;
		nmi_en <= 1;
		global_irq_enable <= 1;
		repeat (3) @(posedge mclk);
		chk_lv(32'h20, 32'h30);
		nmi_en <= 0;
		repeat (3) @(posedge mclk);
		chk_lv(32'h10, 32'h30);
		global_irq_enable <= 0;
		repeat (3) @(posedge mclk);
		chk_lv(0, 32'h30);
		$display("priority test done");
		r = $urandom & 32'hf;
		bus(1, 4'h8, r);
		rd_chk(4'h8, r, 32'hf);
		rd_chk(4'h2, 0, 32'hffff_ffff);
		repeat (3) @(posedge mclk);
		$display("register test done");
		give_verdict();
	end
	initial begin
		repeat (30000) @(posedge mclk);
		error_cnt++;
		give_verdict();
	end
endmodule // tb_top
